// file: asmr_map.vh
// constants for the audio stream merge router
`ifndef ASMR_MAP_VH
`define ASMR_MAP_VH
`define ASMR_NPORTS 10
`define ASMR_SLOT_W 8
`define ASMR_PRESET_A 2'h0
`define ASMR_PRESET_B 2'h1
`define ASMR_PRESET_C 2'h2
`define ASMR_PRESET_RST 2'h0
`define ASMR_SRC_MERGE 2'h0
`define ASMR_SRC_P10 2'h1
`define ASMR_SRC_PAIR 2'h2
`define ASMR_SRC_NONE 2'h3
`define ASMR_B_MERGE_LAST 8
`define ASMR_C_MERGE_LAST 7
`define ASMR_C_FWD_LAST 6
`endif

// file: asmr_merge.v
// slot merger: ors together the audio of selected ports
`timescale 1ns/1ps
`default_nettype none
module asmr_merge #(
    parameter NPORTS = 10,
    parameter W = 8
) (
    input wire mclk,
    input wire rst,
    input wire [NPORTS*W-1:0] data_in,
    input wire [NPORTS-1:0] valid_in,
    input wire [NPORTS-1:0] sel,
    output reg [W-1:0] data_out,
    output reg valid_out
);
    reg [W-1:0] acc;
    reg any;
    integer i;
    // sources own disjoint slots, so an or gives distinct slots in one word
    always @*
    begin
        acc = {W{1'b0}};
        any = 1'b0;
        for (i = 0; i < NPORTS; i = i + 1)
        begin
            if (sel[i] && valid_in[i])
            begin
                acc = acc | data_in[i*W +: W]; // [R17]
                any = 1'b1;
            end
        end
    end
    always @(posedge mclk)
    begin
        if (rst)
        begin
            data_out <= {W{1'b0}};
            valid_out <= 1'b0;
        end
        else
        begin
            data_out <= acc;
            valid_out <= any;
        end
    end
endmodule // asmr_merge
`default_nettype wire

// file: asmr_router.v
// ten-port merge and distribute router core
// Overview of operation
// R1: automatic mode merges audio and aux data of all ten ports, sends to all.
// R2: every port receives and transmits at the same time.
// R3: three manual presets A, B, C held locally in this hub.
// R4: preset A routes exactly like automatic mode.
// R5: preset B merges audio of ports 1-9, sends only on port 10.
// R6: preset B forwards port 10 receive stream to ports 1-9.
// R7: preset B still merges aux data from all ten ports.
// R8: preset C merges audio of ports 1-8, sends on 8 and 9/10.
// R9: preset C forwards audio of ports 9 and 10 to ports 1-7.
// R10: preset C merges aux data from all ports regardless of audio.
// R11: preset C treats ports 9 and 10 as a redundant pair.
// R12: outside setup never double-links hubs except ports 9/10 in preset C.
// R13: both linked hubs must use preset C.
// R14: remove redundant 9/10 link before returning to automatic mode.
// R15: selector press advances preset A, B, C cyclically; one always selected.
// R16: entering manual mode applies the stored preset at once.
// R17: merger places disjoint input slots into one output stream.
`timescale 1ns/1ps
`default_nettype none
`include "asmr_map.vh"
module asmr_router #(
    parameter NPORTS = `ASMR_NPORTS,
    parameter W = `ASMR_SLOT_W
) (
    input wire mclk,
    input wire rst,
    input wire manual_mode,
    input wire preset_button,
    input wire [NPORTS*W-1:0] rx_audio,
    input wire [NPORTS-1:0] rx_audio_valid,
    input wire [NPORTS*W-1:0] rx_aux,
    input wire [NPORTS-1:0] rx_aux_valid,
    output reg [NPORTS*W-1:0] tx_audio,
    output reg [NPORTS-1:0] tx_audio_valid,
    output reg [NPORTS*W-1:0] tx_aux,
    output reg [NPORTS-1:0] tx_aux_valid,
    output wire [1:0] preset,
    output wire [2:0] preset_onehot,
    output wire manual_active
);
    reg mode_s1_r;
    reg mode_s2_r;
    reg btn_s1_r;
    reg btn_s2_r;
    reg btn_d_r;
    reg [1:0] preset_r;
    reg [1:0] preset_nxt;
    wire [NPORTS-1:0] audio_sel;
    wire [1:0] src_sel [0:NPORTS-1];
    wire press_w;
    reg [2:0] onehot_r;
    wire [1:0] eff;
    wire [W-1:0] merged_audio;
    wire merged_audio_v;
    wire [W-1:0] merged_aux;
    wire merged_aux_v;
    reg [W-1:0] pair_audio;
    reg pair_v;
    reg [W-1:0] p10_audio;
    reg p10_v;
    integer k;
    genvar g;

    // last port index, zero based, of each merge or forward group
    localparam B_LAST = `ASMR_B_MERGE_LAST;
    localparam C_LAST = `ASMR_C_MERGE_LAST;
    localparam C_FWD_LAST = `ASMR_C_FWD_LAST;

    // mode level comes from the network controller, asynchronous to mclk
    always @(posedge mclk)
    begin
        if (rst)
        begin
            mode_s1_r <= 1'b0;
            mode_s2_r <= 1'b0;
        end
        else
        begin
            mode_s1_r <= manual_mode;
            mode_s2_r <= mode_s1_r;
        end
    end

    // panel button is asynchronous too; the third stage is only for edge detect
    always @(posedge mclk)
    begin
        if (rst)
        begin
            btn_s1_r <= 1'b0;
            btn_s2_r <= 1'b0;
            btn_d_r <= 1'b0;
        end
        else
        begin
            btn_s1_r <= preset_button;
            btn_s2_r <= btn_s1_r;
            btn_d_r <= btn_s2_r;
        end
    end

    // button is assumed debounced outside; one rising edge is one press
    // reset leaves both stages low, matching the idle pin, so no false press
    assign press_w = btn_s2_r & ~btn_d_r;

    always @*
    begin
        preset_nxt = preset_r;
        if (press_w)
        begin
            case (preset_r)
                `ASMR_PRESET_A: preset_nxt = `ASMR_PRESET_B; // [R15]
                `ASMR_PRESET_B: preset_nxt = `ASMR_PRESET_C; // [R15]
                default: preset_nxt = `ASMR_PRESET_A; // [R15]
            endcase
        end
    end

    // indicator word for the stored preset; exactly one bit is ever lit
    function [2:0] hot_of;
        input [1:0] p;
        begin
            case (p)
                `ASMR_PRESET_B: hot_of = 3'h2;
                `ASMR_PRESET_C: hot_of = 3'h4;
                default: hot_of = 3'h1;
            endcase
        end
    endfunction

    // preset survives auto mode so it is ready when manual mode returns
    always @(posedge mclk)
    begin
        if (rst)
        begin
            preset_r <= `ASMR_PRESET_RST;
            onehot_r <= hot_of(`ASMR_PRESET_RST);
        end
        else
        begin
            preset_r <= preset_nxt; // [R3]
            onehot_r <= hot_of(preset_nxt); // [R15]
        end
    end

    assign preset = preset_r;
    assign preset_onehot = onehot_r;
    assign manual_active = mode_s2_r;
    // stored preset takes effect as soon as manual mode is seen
    assign eff = mode_s2_r ? preset_r : `ASMR_PRESET_A; // [R16] [R4]

    function [1:0] port_src;
        input [1:0] p;
        input integer idx;
        begin
            case (p)
                `ASMR_PRESET_B:
                    port_src = (idx == NPORTS - 1) ? `ASMR_SRC_MERGE : `ASMR_SRC_P10; // [R5] [R6]
                `ASMR_PRESET_C:
                    if (idx <= C_FWD_LAST)
                        port_src = `ASMR_SRC_PAIR; // [R9]
                    else
                        port_src = `ASMR_SRC_MERGE; // [R8] [R11]
                default:
                    port_src = `ASMR_SRC_MERGE; // [R1] [R4]
            endcase
        end
    endfunction

    // receive side: which ports feed the audio merger under each preset
    function merge_member;
        input [1:0] p;
        input integer idx;
        begin
            case (p)
                `ASMR_PRESET_B:
                    merge_member = (idx <= B_LAST); // [R5]
                `ASMR_PRESET_C:
                    merge_member = (idx <= C_LAST); // [R8]
                default:
                    merge_member = 1'b1; // [R1] [R4]
            endcase
        end
    endfunction

    // per-port decode of merger membership and transmit source
    generate
        for (g = 0; g < NPORTS; g = g + 1)
        begin : g_route
            assign src_sel[g] = port_src(eff, g);
            assign audio_sel[g] = merge_member(eff, g);
        end
    endgenerate

    asmr_merge #(.NPORTS(NPORTS), .W(W)) u_audio (
        .mclk(mclk),
        .rst(rst),
        .data_in(rx_audio),
        .valid_in(rx_audio_valid),
        .sel(audio_sel),
        .data_out(merged_audio),
        .valid_out(merged_audio_v)
    );

    // aux channel always merged from every port, whatever the preset
    asmr_merge #(.NPORTS(NPORTS), .W(W)) u_aux (
        .mclk(mclk),
        .rst(rst),
        .data_in(rx_aux),
        .valid_in(rx_aux_valid),
        .sel({NPORTS{1'b1}}), // [R7] [R10] [R1]
        .data_out(merged_aux),
        .valid_out(merged_aux_v)
    );

    // a word not marked valid adds nothing to the redundant pair
    function [W-1:0] gate_word;
        input v;
        input [W-1:0] d;
        begin
            gate_word = v ? d : {W{1'b0}};
        end
    endfunction

    // forwarded paths get one register so they align with the merger
    always @(posedge mclk)
    begin
        if (rst)
        begin
            pair_audio <= {W{1'b0}};
            pair_v <= 1'b0;
            p10_audio <= {W{1'b0}};
            p10_v <= 1'b0;
        end
        else
        begin
            p10_audio <= rx_audio[(NPORTS-1)*W +: W]; // [R6]
            p10_v <= rx_audio_valid[NPORTS-1];
            // redundant pair: whichever link is live feeds ports 1-7
            pair_audio <= gate_word(rx_audio_valid[NPORTS-2], rx_audio[(NPORTS-2)*W +: W]) |
                gate_word(rx_audio_valid[NPORTS-1], rx_audio[(NPORTS-1)*W +: W]); // [R9] [R11]
            pair_v <= rx_audio_valid[NPORTS-2] | rx_audio_valid[NPORTS-1];
        end
    end

    always @(posedge mclk)
    begin
        if (rst)
        begin
            tx_audio <= {NPORTS*W{1'b0}};
            tx_audio_valid <= {NPORTS{1'b0}};
        end
        else
        begin
            for (k = 0; k < NPORTS; k = k + 1)
            begin
                // transmit runs every cycle alongside receive on each port
                // a preset change mixes old and new routing for one cycle only
                case (src_sel[k])
                    `ASMR_SRC_P10:
                    begin
                        tx_audio[k*W +: W] <= p10_audio; // [R6]
                        tx_audio_valid[k] <= p10_v;
                    end
                    `ASMR_SRC_PAIR:
                    begin
                        tx_audio[k*W +: W] <= pair_audio; // [R9]
                        tx_audio_valid[k] <= pair_v;
                    end
                    `ASMR_SRC_MERGE:
                    begin
                        tx_audio[k*W +: W] <= merged_audio; // [R2]
                        tx_audio_valid[k] <= merged_audio_v;
                    end
                    default:
                    begin
                        tx_audio[k*W +: W] <= {W{1'b0}};
                        tx_audio_valid[k] <= 1'b0;
                    end
                endcase
            end
        end
    end

    // aux broadcast kept apart from the audio mux; it never depends on preset
    always @(posedge mclk)
    begin
        if (rst)
        begin
            tx_aux <= {NPORTS*W{1'b0}};
            tx_aux_valid <= {NPORTS{1'b0}};
        end
        else
        begin
            tx_aux <= {NPORTS{merged_aux}}; // [R2] [R7] [R10]
            tx_aux_valid <= {NPORTS{merged_aux_v}};
        end
    end
endmodule // asmr_router
`default_nettype wire

// file: asmr_far_end.sv
// far-end stream sources feeding all ten ports
`timescale 1ns/1ps
`default_nettype none
module asmr_far_end (
    input wire logic [9:0] mask,
    output wire logic [79:0] rx_audio,
    output wire logic [9:0] rx_audio_valid,
    output wire logic [79:0] rx_aux,
    output wire logic [9:0] rx_aux_valid
);
    genvar p;
    // one single link per port, so no loop can form
    generate
        for (p = 0; p < 10; p = p + 1)
        begin : g_src
            // ports 8-10 own a slot bit each, ports 1-7 share one
            localparam [7:0] PAT = (p < 7) ? 8'h01 : (8'h01 << (p - 6));
            // a silent port shows the inverted word, not stale data
            assign rx_audio[p*8+:8] = mask[p] ? PAT : ~PAT;
            assign rx_aux[p*8+:8] = mask[p] ? (PAT << 4) : ~(PAT << 4);
        end
    endgenerate
    assign rx_audio_valid = mask;
    assign rx_aux_valid = mask;
endmodule // asmr_far_end
`default_nettype wire

// file: asmr_router_props.sv
// assertions on the router ports
`timescale 1ns/1ps
`default_nettype none
`include "asmr_map.vh"
module asmr_props #(
    parameter NPORTS = 10,
    parameter W = 8
) (
    input wire mclk,
    input wire rst,
    input wire manual_mode,
    input wire preset_button,
    input wire [NPORTS*W-1:0] rx_audio,
    input wire [NPORTS-1:0] rx_audio_valid,
    input wire [NPORTS*W-1:0] rx_aux,
    input wire [NPORTS-1:0] rx_aux_valid,
    input wire [NPORTS*W-1:0] tx_audio,
    input wire [NPORTS-1:0] tx_audio_valid,
    input wire [NPORTS*W-1:0] tx_aux,
    input wire [NPORTS-1:0] tx_aux_valid,
    input wire [1:0] preset,
    input wire [2:0] preset_onehot,
    input wire manual_active
);
    // pipeline still holds reset-time words for two cycles
    reg [1:0] rst_h_r = 2'h3;
    always @(posedge mclk) rst_h_r <= {rst_h_r[0], rst};
    function [W-1:0] mrg(input [NPORTS*W-1:0] d, input [NPORTS-1:0] v, input [NPORTS-1:0] s);
        integer i;
        begin
            mrg = {W{1'b0}};
            for (i = 0; i < NPORTS; i = i + 1)
                if (v[i] && s[i]) mrg = mrg | d[i*W+:W];
        end
    endfunction
    default clocking @(posedge mclk); endclocking
    default disable iff (rst || rst_h_r != 2'h0);
    sequence s_press; !preset_button ##1 preset_button; endsequence
    sequence s_auto; (!manual_active) [*6]; endsequence
    sequence s_b; (manual_active && preset == `ASMR_PRESET_B) [*6]; endsequence
    sequence s_c; (manual_active && preset == `ASMR_PRESET_C) [*6]; endsequence
    property p_aux; tx_aux[W-1:0] == $past(mrg(rx_aux, rx_aux_valid, 10'h3ff), 2); endproperty
    property p_hot; preset != 2'h3 && preset_onehot == (3'h1 << preset); endproperty
    property p_cyc; $changed(preset) |->
        preset == (($past(preset) == `ASMR_PRESET_C) ? `ASMR_PRESET_A : $past(preset) + 2'h1);
    endproperty
    property p_press; s_press |-> ##[1:4] $changed(preset); endproperty
    property p_mode; manual_mode [*4] |-> manual_active; endproperty
    property p_auto; s_auto |->
        tx_audio[W-1:0] == $past(mrg(rx_audio, rx_audio_valid, 10'h3ff), 2); endproperty
    property p_b; s_b |->
        tx_audio[9*W+:W] == $past(mrg(rx_audio, rx_audio_valid, 10'h1ff), 2); endproperty
    property p_c; s_c |->
        tx_audio[W-1:0] == $past(mrg(rx_audio, rx_audio_valid, 10'h300), 2); endproperty
    property p_bfwd; s_b |-> tx_audio[W-1:0] == $past(rx_audio[9*W+:W], 2); endproperty
    property p_c8; s_c |->
        tx_audio[7*W+:W] == $past(mrg(rx_audio, rx_audio_valid, 10'h0ff), 2); endproperty
    a_aux: assert property (p_aux) else $error("aux merge wrong");
    a_hot: assert property (p_hot) else $error("preset one-hot wrong");
    a_cyc: assert property (p_cyc) else $error("preset order wrong");
    a_press: assert property (p_press) else $error("press ignored");
    a_mode: assert property (p_mode) else $error("manual mode not taken");
    a_auto: assert property (p_auto) else $error("auto merge wrong");
    a_b: assert property (p_b) else $error("preset B port 10 wrong");
    a_c: assert property (p_c) else $error("preset C pair forward wrong");
    a_bfwd: assert property (p_bfwd) else $error("preset B port 10 forward wrong");
    a_c8: assert property (p_c8) else $error("preset C port 8 merge wrong");
endmodule // asmr_props
bind asmr_router asmr_props #(.NPORTS(NPORTS), .W(W)) u_props (.mclk(mclk), .rst(rst),
    .manual_mode(manual_mode), .preset_button(preset_button), .rx_audio(rx_audio),
    .rx_audio_valid(rx_audio_valid), .rx_aux(rx_aux), .rx_aux_valid(rx_aux_valid),
    .tx_audio(tx_audio), .tx_audio_valid(tx_audio_valid), .tx_aux(tx_aux),
    .tx_aux_valid(tx_aux_valid), .preset(preset), .preset_onehot(preset_onehot),
    .manual_active(manual_active));
`default_nettype wire

// file: asmr_router_tb_top.sv
// self-checking bench for the merge router
`timescale 1ns/1ps
`default_nettype none
module asmr_router_tb_top;
    logic mclk = 1'b0, rst = 1'b1, manual_mode = 1'b0, preset_button = 1'b0;
    logic [9:0] mask = 10'h000;
    wire [79:0] rxa, rxx, txa, txx;
    wire [9:0] rxav, rxxv, txav, txxv;
    wire [1:0] preset;
    wire [2:0] onehot;
    wire man_act;
    integer err_count = 0, checks_done = 0, n;
    initial forever #2.5 mclk = ~mclk;
    asmr_far_end u_far (.mask(mask), .rx_audio(rxa), .rx_audio_valid(rxav), .rx_aux(rxx),
        .rx_aux_valid(rxxv));
    asmr_router u_dut (.mclk(mclk), .rst(rst), .manual_mode(manual_mode),
        .preset_button(preset_button), .rx_audio(rxa), .rx_audio_valid(rxav), .rx_aux(rxx),
        .rx_aux_valid(rxxv), .tx_audio(txa), .tx_audio_valid(txav), .tx_aux(txx),
        .tx_aux_valid(txxv), .preset(preset), .preset_onehot(onehot), .manual_active(man_act));
    function automatic [7:0] pat(input integer p);
        pat = (p < 7) ? 8'h01 : (8'h01 << (p - 6));
    endfunction
    function automatic [7:0] mrg(input [9:0] s);
        integer q;
        begin
            mrg = 8'h00;
            for (q = 0; q < 10; q = q + 1)
                if (s[q] && mask[q]) mrg = mrg | pat(q);
        end
    endfunction
    task stop_test;
        begin
            $display("checks %0d errors %0d", checks_done, err_count);
            if (err_count == 0 && checks_done > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp)
            begin
                err_count = err_count + 1;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task settle;
        repeat (8) @(posedge mclk);
    endtask
    task ports(input [1:0] pre);
        logic [9:0] s;
        logic [7:0] e;
        integer p;
        for (p = 0; p < 10; p = p + 1)
        begin
            s = (pre == 2'h0) ? 10'h3ff : (pre == 2'h1) ? ((p == 9) ? 10'h1ff : 10'h200)
                : ((p >= 7) ? 10'h0ff : 10'h300);
            // port 10 words reach ports 1-9 as received, valid or not
            e = (pre == 2'h1 && p != 9) ? (mask[9] ? pat(9) : ~pat(9)) : mrg(s);
            chk(txa[p*8+:8], e);
            chk({7'h00, txav[p]}, {7'h00, |(s & mask)});
            chk(txx[p*8+:8], mrg(10'h3ff) << 4);
            chk({7'h00, txxv[p]}, {7'h00, |mask});
        end
    endtask
    task press(input [1:0] exp);
        begin
            #1 preset_button = 1'b1;
            for (n = 0; n < 10 && preset !== exp; n = n + 1)
                @(posedge mclk);
            if (preset !== exp)
            begin
                err_count = err_count + 1;
                $display("[ERR] %0t preset did not advance", $time);
                stop_test;
            end
            chk({5'h00, onehot}, 8'h01 << exp);
            #1 preset_button = 1'b0;
            settle;
        end
    endtask
    task t_auto;
        begin
            #1 mask = 10'h3ff;
            settle;
            ports(2'h0);
            #1 mask = 10'h2fe;
            settle;
            ports(2'h0);
            $display("auto mode done");
        end
    endtask
    task t_manual;
        begin
            #1 manual_mode = 1'b1;
            settle;
            chk({7'h00, man_act}, 8'h01);
            ports(2'h0);
            press(2'h1);
            ports(2'h1);
            press(2'h2);
            ports(2'h2);
            #1 mask = 10'h1ff;
            settle;
            ports(2'h2);
            $display("manual presets done");
        end
    endtask
    task t_wrap;
        begin
            press(2'h0);
            ports(2'h0);
            #1 manual_mode = 1'b0;
            press(2'h1);
            ports(2'h0);
            chk({7'h00, man_act}, 8'h00);
            #1 manual_mode = 1'b1;
            settle;
            ports(2'h1);
            $display("preset wrap done");
        end
    endtask
    task t_reset;
        begin
            #1 rst = 1'b1;
            repeat (2) @(posedge mclk);
            #1 chk(txa[7:0], 8'h00);
            chk({6'h00, preset}, 8'h00);
            chk({7'h00, man_act}, 8'h00);
            rst = 1'b0;
            settle;
            ports(2'h0);
            $display("mid-run reset done");
        end
    endtask
    initial
    begin
        repeat (6) @(posedge mclk);
        #1 rst = 1'b0;
        @(posedge mclk);
        t_auto;
        t_manual;
        t_wrap;
        t_reset;
        stop_test;
    end
endmodule // asmr_router_tb_top
`default_nettype wire
